/* File: design/olq_monitor.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - Mode bits 15..13 retained and read back
// - Reset bit self-clears when reset completes
// - Partner header status bit reads zero initially
// - Link-reliable bit reads zero before reliability
// - Not established: status zero, margin 80h
// - Partner header OK leads to request set one
// - Requested coefficients are all nonzero
// - Partner announces set one: precoder bit set
// - Correct precoder gives margin 00h to 7Fh
// - Non-negative margin reports link OK
// - Reliable link sets link-reliable bit
// - Wrong coefficients report negative margin
// - Negative margin reports link not OK
// - Precoder bit stays while set one announced
// - Negative margin clears link-reliable bit
module olq_monitor #(
    parameter int BUF_DEPTH = 2,
    parameter int RST_CYCLES = olq_pkg::SOFT_RST_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire olq_pkg::olq_rx_t rx_report,
    input wire logic tx_tick,
    output logic tx_tick_ready,
    output logic tx_valid,
    input wire logic tx_ready,
    output olq_pkg::olq_tx_t tx_hdr
);

    ////////////////////////////////////////////////////////////////////////////////
    // Parameter checks

    if (BUF_DEPTH != 2)
    begin : g_depth_chk
        $error("olq_monitor: BUF_DEPTH must be 2");
    end
    if (RST_CYCLES < 1 || RST_CYCLES > 255)
    begin : g_rst_chk
        $error("olq_monitor: RST_CYCLES must be 1 to 255");
    end

    // Nonzero coefficient for one tap index
    function automatic logic [olq_pkg::COEF_W-1:0] coef_value(input int idx);
        coef_value = olq_pkg::COEF_BASE + olq_pkg::COEF_W'(idx);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    logic [olq_pkg::MODE_SEL_W-1:0] mode_sel;
    logic rst_busy;
    logic [olq_pkg::RST_CNT_W-1:0] rst_cnt;
    olq_pkg::olq_state_t state;
    olq_pkg::olq_state_t next_state;
    logic partner_hdr_ok;
    logic reliable;
    logic rx_seen;
    logic [olq_pkg::MARGIN_W-1:0] margin;
    logic ent_valid [0:1];
    olq_pkg::olq_tx_t ent [0:1];
    logic next_ent_valid [0:1];
    olq_pkg::olq_tx_t next_ent [0:1];

    ////////////////////////////////////////////////////////////////////////////////
    // APB decode

    // Bus phases of the current transfer
    wire setup = psel & ~penable;
    wire access = psel & penable & pready;
    wire wr_access = access & pwrite;
    // Address decode; an unmapped address answers with an error
    wire hit_ctrl = paddr == olq_pkg::OFS_CTRL;
    wire hit_mode = paddr == olq_pkg::OFS_MODE;
    wire hit_status = paddr == olq_pkg::OFS_STATUS;
    wire hit_margin = paddr == olq_pkg::OFS_MARGIN;
    wire hit_any = hit_ctrl | hit_mode | hit_status | hit_margin;
    // Soft reset request and precoder-in-use flag
    wire soft_rst_req = wr_access & hit_ctrl & pwdata[olq_pkg::CTRL_RESET_BIT];
    wire precoder_on = state == olq_pkg::OLQ_RUN;

    // Read data selection
    wire [31:0] rd_ctrl = 32'(rst_busy) << olq_pkg::CTRL_RESET_BIT;
    wire [31:0] rd_mode = 32'(mode_sel) << olq_pkg::MODE_SEL_LSB;
    wire [31:0] rd_status = (32'(reliable) << olq_pkg::ST_RELIABLE_BIT)
        | (32'(partner_hdr_ok) << olq_pkg::ST_HDR_OK_BIT)
        | (32'(precoder_on) << olq_pkg::ST_PRECODER_BIT);
    wire [31:0] rd_margin = 32'(margin);
    wire [31:0] rd_data = hit_ctrl ? rd_ctrl
        : hit_mode ? rd_mode
        : hit_status ? rd_status
        : hit_margin ? rd_margin : 32'h0000_0000;

    // Answer registered at setup so the access phase ends after one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (ce)
        begin
            pready <= setup;
            pslverr <= setup & ~hit_any;
            prdata <= setup ? rd_data : 32'h0000_0000;
        end
    end

    // Mode select field survives the soft reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_sel <= olq_pkg::MODE_SEL_RST;
        else if (ce && wr_access && hit_mode)
            mode_sel <= pwdata[olq_pkg::MODE_SEL_LSB +: olq_pkg::MODE_SEL_W];
    end

    // Soft reset: busy flag reads back until the count runs out
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_busy <= 1'b0;
            rst_cnt <= '0;
        end
        else if (ce)
        begin
            if (soft_rst_req)
            begin
                rst_busy <= 1'b1;
                rst_cnt <= olq_pkg::RST_CNT_W'(RST_CYCLES - 1);
            end
            else if (rst_busy)
            begin
                rst_busy <= rst_cnt != '0;
                rst_cnt <= rst_cnt - 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Quality monitor state machine, stepped once per received block

    // Report fields that steer the state machine
    wire hdr_in_ok = rx_report.hdr_header_received_ok;
    wire set_one_in = rx_report.hdr_next_precoder_set == olq_pkg::SET_ONE;
    wire margin_neg_in = rx_report.rx_margin[olq_pkg::MARGIN_W-1];

    always_comb
    begin
        next_state = state;
        unique case (state)
            olq_pkg::OLQ_IDLE:
                if (hdr_in_ok)
                    next_state = olq_pkg::OLQ_REQ;
            olq_pkg::OLQ_REQ:
                if (!hdr_in_ok)
                    next_state = olq_pkg::OLQ_IDLE;
                else if (set_one_in)
                    next_state = olq_pkg::OLQ_RUN;
            olq_pkg::OLQ_RUN:
                if (!hdr_in_ok || !set_one_in)
                    next_state = olq_pkg::OLQ_IDLE;
            default:
                next_state = olq_pkg::OLQ_IDLE;
        endcase
    end

    // Margin, reliability and state move together on the same block
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= olq_pkg::OLQ_IDLE;
            partner_hdr_ok <= 1'b0;
            reliable <= 1'b0;
            rx_seen <= 1'b0;
            margin <= olq_pkg::MARGIN_NONE;
        end
        else if (ce)
        begin
            if (rst_busy)
            begin
                state <= olq_pkg::OLQ_IDLE;
                partner_hdr_ok <= 1'b0;
                reliable <= 1'b0;
                rx_seen <= 1'b0;
                margin <= olq_pkg::MARGIN_NONE;
            end
            else if (rx_valid)
            begin
                state <= next_state;
                partner_hdr_ok <= hdr_in_ok;
                rx_seen <= 1'b1;
                margin <= rx_report.rx_margin;
                reliable <= next_state == olq_pkg::OLQ_RUN && !margin_neg_in;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit header built from the registered state

    olq_pkg::olq_tx_t new_hdr;
    always_comb
    begin
        new_hdr.hdr_header_received_ok = rx_seen;
        new_hdr.hdr_receive_link_ok = reliable;
        new_hdr.hdr_next_tx_mode = 1'b0;
        new_hdr.hdr_link_margin = precoder_on ? margin : olq_pkg::MARGIN_NONE;
        new_hdr.hdr_requested_precoder_set =
            (state == olq_pkg::OLQ_IDLE) ? olq_pkg::SET_NONE : olq_pkg::SET_ONE;
        for (int i = 0; i < olq_pkg::COEF_N; i++)
            new_hdr.hdr_requested_precoder_coefs[i] = coef_value(i);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Two-entry buffer: entry 0 drives the outputs, entry 1 catches a stall

    // A push takes a new header, a pop hands entry 0 to the link
    wire push = tx_tick & tx_tick_ready;
    wire pop = ent_valid[0] & tx_ready;

    always_comb
    begin
        for (int i = 0; i < 2; i++)
        begin
            next_ent_valid[i] = ent_valid[i];
            next_ent[i] = ent[i];
        end
        if (pop)
        begin
            if (ent_valid[1])
            begin
                next_ent[0] = ent[1];
                next_ent_valid[1] = 1'b0;
            end
            else
                next_ent_valid[0] = 1'b0;
        end
        if (push)
        begin
            if (!next_ent_valid[0])
            begin
                next_ent_valid[0] = 1'b1;
                next_ent[0] = new_hdr;
            end
            else
            begin
                next_ent_valid[1] = 1'b1;
                next_ent[1] = new_hdr;
            end
        end
    end

    // Buffer storage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 2; i++)
            begin
                ent_valid[i] <= 1'b0;
                ent[i] <= '0;
            end
        end
        else if (ce)
        begin
            for (int i = 0; i < 2; i++)
            begin
                ent_valid[i] <= next_ent_valid[i];
                ent[i] <= next_ent[i];
            end
        end
    end

    // Ready toward the block generator while the spare entry is free
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            tx_tick_ready <= 1'b1;
        else if (ce)
            tx_tick_ready <= !next_ent_valid[1];
    end

    // Entry 0 faces the link side
    assign tx_valid = ent_valid[0]; // Flop output
    assign tx_hdr = ent[0]; // Flop output

endmodule

/* File: design/olq_pkg.sv */
package olq_pkg;

    // Register byte offsets on the APB bus
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_MARGIN = 8'h0C;

    // Field positions
    localparam int CTRL_RESET_BIT = 15;
    localparam int MODE_SEL_LSB = 13;
    localparam int MODE_SEL_W = 3;
    localparam int ST_RELIABLE_BIT = 15;
    localparam int ST_HDR_OK_BIT = 10;
    localparam int ST_PRECODER_BIT = 9;

    // Reset values and codes
    localparam logic [MODE_SEL_W-1:0] MODE_SEL_RST = 3'h0;
    localparam int MARGIN_W = 8;
    localparam logic [MARGIN_W-1:0] MARGIN_NONE = 8'h80;
    localparam int SET_W = 2;
    localparam logic [SET_W-1:0] SET_NONE = 2'h0;
    localparam logic [SET_W-1:0] SET_ONE = 2'h1;
    localparam int COEF_N = 9;
    localparam int COEF_W = 8;
    localparam logic [COEF_W-1:0] COEF_BASE = 8'h11;

    // Timing: soft reset duration
    localparam int CLK_PERIOD_NS = 10;
    localparam int SOFT_RST_TIME_NS = 100;
    localparam int SOFT_RST_CYCLES = (SOFT_RST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 8;

    // Report of one received block: partner header plus measured margin
    typedef struct packed {
        logic hdr_header_received_ok;
        logic hdr_receive_link_ok;
        logic hdr_next_tx_mode;
        logic [SET_W-1:0] hdr_next_precoder_set;
        logic [SET_W-1:0] hdr_requested_precoder_set;
        logic [MARGIN_W-1:0] rx_margin;
    } olq_rx_t;

    // Header fields of one transmitted block
    typedef struct packed {
        logic hdr_header_received_ok;
        logic hdr_receive_link_ok;
        logic hdr_next_tx_mode;
        logic [MARGIN_W-1:0] hdr_link_margin;
        logic [SET_W-1:0] hdr_requested_precoder_set;
        logic [COEF_N-1:0][COEF_W-1:0] hdr_requested_precoder_coefs;
    } olq_tx_t;

    // Monitor states
    typedef enum logic [2:0] {
        OLQ_IDLE = 3'b001,
        OLQ_REQ = 3'b010,
        OLQ_RUN = 3'b100
    } olq_state_t;

endpackage

/* File: testbench/olq_chk_monitor.sv */
`timescale 1ns/100ps
module olq_chk #(
    parameter int BUF_DEPTH = 2,
    parameter int RST_CYCLES = 10
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire olq_pkg::olq_tx_t tx_hdr
);
    logic cz;
    logic lok;
    logic [1:0] req;
    logic [7:0] mg;
    logic setup;
    logic st_rd;
    // Header fields, bus phases and a zero coefficient flag
    assign lok = tx_hdr.hdr_receive_link_ok;
    assign req = tx_hdr.hdr_requested_precoder_set;
    assign mg = tx_hdr.hdr_link_margin;
    assign setup = psel && !penable && ce;
    assign st_rd = pready && !pwrite && paddr == olq_pkg::OFS_STATUS;
    always_comb
    begin
        cz = 1'b0;
        for (int i = 0; i < olq_pkg::COEF_N; i++)
            cz = cz | (tx_hdr.hdr_requested_precoder_coefs[i] == 8'h00);
    end
    ////////////////////////////////////////
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    chk_apb_answer: assert property (setup |=> pready)
        else $error("access not answered");
    chk_apb_once: assert property (pready && ce |=> !pready)
        else $error("pready held");
    chk_bad_addr: assert property (setup && paddr > 8'h0C |=> pslverr && prdata == 32'h0)
        else $error("unmapped access accepted");
    chk_idle_read: assert property (!pready |-> prdata == 32'h0 && !pslverr)
        else $error("read data outside access");
    chk_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_hdr))
        else $error("header lost in stall");
    chk_coef_nz: assert property (tx_valid && req == olq_pkg::SET_ONE |-> !cz)
        else $error("zero coefficient requested");
    chk_idle_hdr: assert property (tx_valid && req == olq_pkg::SET_NONE |-> {lok, mg} == 9'h080)
        else $error("idle header wrong");
    chk_link_sign: assert property (tx_valid |-> lok == !mg[7])
        else $error("link status and margin disagree");
    chk_run_flag: assert property (st_rd && prdata[15] |-> prdata[9])
        else $error("reliable without precoder");
endmodule
bind olq_monitor olq_chk #(.BUF_DEPTH(BUF_DEPTH), .RST_CYCLES(RST_CYCLES)) chk_u (
    .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .tx_valid, .tx_ready, .tx_hdr
);

/* File: testbench/olq_monitor_tb_top.sv */
`timescale 1ns/100ps
`define CHK(a, e) \
    begin \
        total_checks++; \
        if ((a) !== (e)) \
        begin \
            failures++; \
            $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); \
        end \
    end
module olq_monitor_tb_top;
    localparam int BLK = 16;
    localparam logic [31:0] SM = 32'h8600;
    localparam logic [7:0] ST = olq_pkg::OFS_STATUS;
    logic pclk, presetn, psel, penable, pwrite, hdr_ok, stall;
    logic ce;
    logic [7:0] paddr, margin;
    logic [31:0] pwdata, prdata, wd;
    logic [32:0] rd;
    logic [1:0] next_set;
    logic pready, pslverr, rx_valid, tx_tick, tx_tick_ready, tx_valid, tx_ready;
    olq_pkg::olq_rx_t rx_report;
    olq_pkg::olq_tx_t tx_hdr, last_hdr;
    int failures = 0;
    int total_checks = 0;
    int cyc = 0;
    olq_monitor #(.BUF_DEPTH(2), .RST_CYCLES(6)) dut_u (
        .pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .rx_valid, .rx_report, .tx_tick, .tx_tick_ready, .tx_valid,
        .tx_ready, .tx_hdr
    );
    olq_partner #(.BLK(BLK)) bfm_u (
        .pclk, .presetn, .hdr_ok, .next_set, .margin, .stall, .tx_tick_ready, .tx_valid,
        .tx_hdr, .rx_valid, .rx_report, .tx_tick, .tx_ready, .last_hdr
    );
    ////////////////////////////////////////
    // Clock and hang limit
    always #5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            failures++;
            results();
        end
    end
    // One APB transfer, result kept with its error flag
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    // Reads until the masked value shows, at most sixty-one times
    task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
        apb(1'b0, a, 32'h0);
        for (int n = 0; n < 60 && (rd[31:0] & m) !== v; n++)
            apb(1'b0, a, 32'h0);
    endtask
    task automatic blocks(input int n);
        repeat (n * BLK) @(posedge pclk);
    endtask
    function automatic logic [31:0] exp_st(input logic rel, input logic hok, input logic run);
        exp_st = 32'h0;
        exp_st[olq_pkg::ST_RELIABLE_BIT] = rel;
        exp_st[olq_pkg::ST_HDR_OK_BIT] = hok;
        exp_st[olq_pkg::ST_PRECODER_BIT] = run;
    endfunction
    task automatic results();
        if (failures == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////
    // Main sequence
    initial
    begin
        {pclk, presetn, psel, penable, pwrite, hdr_ok, stall} = 7'h00;
        ce = 1'b1;
        {paddr, margin, pwdata, next_set} = 50'h0;
        void'($urandom(32'hB682));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        blocks(2);
        apb(1'b0, ST, 32'h0);
        `CHK(rd & SM, exp_st(0, 0, 0))
        `CHK({last_hdr.hdr_receive_link_ok, last_hdr.hdr_link_margin}, 9'h080)
        for (int i = 0; i < 4; i++)
        begin
            wd = (i == 0) ? 32'h2000 : $urandom;
            apb(1'b1, olq_pkg::OFS_MODE, wd);
            apb(1'b0, olq_pkg::OFS_MODE, 32'h0);
            `CHK(rd & 32'hE000, wd & 32'hE000)
        end
        apb(1'b0, 8'h10, 32'h0);
        `CHK(rd, 33'h1_0000_0000)
        apb(1'b1, ST, 32'hFFFF_FFFF);
        apb(1'b0, ST, 32'h0);
        `CHK(rd & SM, 32'h0)
        apb(1'b1, olq_pkg::OFS_CTRL, 32'h8000);
        apb(1'b0, olq_pkg::OFS_CTRL, 32'h0);
        `CHK(rd[15], 1'b1)
        poll(olq_pkg::OFS_CTRL, 32'h8000, 32'h0);
        `CHK(rd[15], 1'b0)
        apb(1'b0, olq_pkg::OFS_MODE, 32'h0);
        `CHK(rd & 32'hE000, wd & 32'hE000)
        hdr_ok <= 1'b1;
        poll(ST, 32'h0400, 32'h0400);
        `CHK(rd & SM, exp_st(0, 1, 0))
        blocks(3);
        `CHK(last_hdr.hdr_requested_precoder_set, olq_pkg::SET_ONE)
        for (int i = 0; i < olq_pkg::COEF_N; i++)
            `CHK(last_hdr.hdr_requested_precoder_coefs[i] != 8'h00, 1'b1)
        for (int k = 0; k < 4; k++)
        begin
            next_set <= olq_pkg::SET_ONE;
            margin <= (k == 0) ? 8'h7F : (k == 1) ? 8'h00 : 8'($urandom) & 8'h7F;
            poll(ST, SM, exp_st(1, 1, 1));
            `CHK(rd & SM, exp_st(1, 1, 1))
            blocks(3);
            `CHK(last_hdr.hdr_link_margin, margin)
            `CHK(last_hdr.hdr_receive_link_ok, 1'b1)
            // Clock enable low: a negative report must not reach the status
            ce <= 1'b0;
            margin <= 8'($urandom) | 8'h80;
            blocks(2);
            ce <= 1'b1;
            apb(1'b0, ST, 32'h0);
            `CHK(rd & SM, exp_st(1, 1, 1))
            margin <= (k == 0) ? 8'h80 : 8'($urandom) | 8'h80;
            blocks(3);
            apb(1'b0, ST, 32'h0);
            `CHK(rd & SM, exp_st(0, 1, 1))
            apb(1'b0, olq_pkg::OFS_MARGIN, 32'h0);
            `CHK(rd, {25'h000_0000, margin})
            `CHK(last_hdr.hdr_link_margin, margin)
            `CHK(last_hdr.hdr_receive_link_ok, 1'b0)
        end
        stall <= 1'b1;
        for (int n = 0; n < 100 && tx_tick_ready !== 1'b0; n++)
            @(posedge pclk);
        `CHK({tx_tick_ready, tx_valid}, 2'b01)
        stall <= 1'b0;
        hdr_ok <= 1'b0;
        poll(ST, SM, 32'h0);
        `CHK(rd & SM, exp_st(0, 0, 0))
        blocks(3);
        `CHK({last_hdr.hdr_requested_precoder_set, last_hdr.hdr_link_margin}, 10'h080)
        `CHK({last_hdr.hdr_header_received_ok, last_hdr.hdr_next_tx_mode}, 2'b10)
        // Mid-run reset: outputs idle at once, mode field back to its reset value
        presetn <= 1'b0;
        @(posedge pclk);
        `CHK({pready, pslverr, tx_valid, tx_tick_ready, prdata}, 36'h1_0000_0000)
        presetn <= 1'b1;
        apb(1'b0, olq_pkg::OFS_MODE, 32'h0);
        `CHK(rd & 32'hE000, {16'h0000, olq_pkg::MODE_SEL_RST, 13'h0000})
        apb(1'b0, ST, 32'h0);
        `CHK(rd & SM, exp_st(0, 0, 0))
        results();
    end
endmodule

/* File: testbench/olq_partner.sv */
`timescale 1ns/100ps
module olq_partner #(
    parameter int BLK = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic hdr_ok,
    input wire logic [1:0] next_set,
    input wire logic [7:0] margin,
    input wire logic stall,
    input wire logic tx_tick_ready,
    input wire logic tx_valid,
    input wire olq_pkg::olq_tx_t tx_hdr,
    output logic rx_valid,
    output olq_pkg::olq_rx_t rx_report,
    output logic tx_tick,
    output logic tx_ready,
    output olq_pkg::olq_tx_t last_hdr
);
    logic [7:0] cnt;
    logic blk_end;
    assign blk_end = cnt == 8'(BLK - 1);
    // Block timing, partner header out, header sink in
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt <= 8'h00;
            rx_valid <= 1'b0;
            rx_report <= '0;
            tx_tick <= 1'b0;
            tx_ready <= 1'b0;
            last_hdr <= '0;
        end
        else
        begin
            cnt <= blk_end ? 8'h00 : cnt + 8'h01;
            rx_valid <= blk_end;
            rx_report <= blk_end ? {hdr_ok, 2'b00, next_set, 2'h0, margin} : ~rx_report;
            tx_tick <= blk_end | (tx_tick & ~tx_tick_ready); // Held until taken
            tx_ready <= ~stall;
            if (tx_valid && tx_ready)
                last_hdr <= tx_hdr;
        end
    end
endmodule
